// File: tx_ramp_cfg.svh
// Purpose: Register map, field positions, reset values and step counts
// Assumes: Register indices are word indices on APB (byte address = 4 * index)
// Notes:   Definitions only
`ifndef TX_RAMP_CFG_SVH
`define TX_RAMP_CFG_SVH

`define IDX_DWELL        10'h004
`define IDX_RAMP_UP      10'h005
`define IDX_RAMP_DOWN    10'h006
`define IDX_CTRL         10'h008
`define IDX_STATUS       10'h009

`define DWELL_HWEN_BIT   7
`define DWELL_RSVD_BIT   6
`define DWELL_CNT_MSB    5
`define GAP_HI_MSB       7
`define GAP_HI_LSB       4
`define GAP_LO_MSB       3
`define CTRL_DOUBLE_BIT  0
`define CTRL_SWSEL_BIT   1
`define CTRL_LOAD_BIT    2

`define DWELL_RST        8'h00
`define RAMP_UP_RST      8'h00
`define RAMP_DOWN_RST    8'h00
`define CTRL_RST         8'h00

`define STEP_SHORT       6'd20
`define STEP_LONG        6'd40

`endif

// File: tx_ramp_pkg.sv
// Purpose: Shared types of the transmit ramp and antenna dwell block
// Assumes: Nothing beyond the configuration header
// Notes:   State codes are one-hot
`default_nettype none
package tx_ramp_pkg;

  typedef enum logic [5:0] {
    RAMP_IDLE = 6'h01,
    RAMP_UP_B = 6'h02,
    RAMP_UP_C = 6'h04,
    RAMP_ON   = 6'h08,
    RAMP_DN_B = 6'h10,
    RAMP_DN_A = 6'h20
  } ramp_state_t;

  typedef logic [7:0] reg8_t;

endpackage : tx_ramp_pkg
`default_nettype wire

// File: step_tick_gen.sv
// Purpose: One-cycle step pulse every 20 or 40 clocks
// Assumes: mclk is the input clock of the step unit
// Notes:   clear restarts the period so a phase lasts whole steps
`timescale 1ns/1ps
`default_nettype none
`include "tx_ramp_cfg.svh"
module step_tick_gen (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic stepDouble,
  output logic      tick
);
  import tx_ramp_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
  } tick_state_t;

  tick_state_t st;
  tick_state_t next_st;
  logic [5:0]  lastCount;

  assign lastCount = stepDouble ? (`STEP_LONG - 6'd1) : (`STEP_SHORT - 6'd1);
  assign tick      = !clear && (st.cnt >= lastCount);

  always_comb begin
    next_st = st;
    if (clear || st.cnt >= lastCount) begin
      next_st.cnt = 6'h00;
    end else begin
      next_st.cnt = st.cnt + 6'd1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : step_tick_gen
`default_nettype wire

// File: antenna_dwell_ctrl.sv
// Purpose: Alternates antennas per dwell, records signal strength, picks final antenna
// Assumes: measureActive is high for a whole diversity measurement
// Notes:   A larger strength value means a better antenna
`timescale 1ns/1ps
`default_nettype none
`include "tx_ramp_cfg.svh"
module antenna_dwell_ctrl (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       hwEnable,
  input  wire logic [5:0] dwellCount,
  input  wire logic       stepDouble,
  input  wire logic       measureActive,
  input  wire logic [7:0] rssi,
  input  wire logic       swSelect,
  input  wire logic       swLoad,
  output logic            antennaSel,
  output logic            measuring
);
  import tx_ramp_pkg::*;

  typedef struct packed {
    logic       active;
    logic       ant;
    logic       finalAnt;
    logic [5:0] steps;
    logic [7:0] rssiA;
    logic [7:0] rssiB;
  } dwell_state_t;

  dwell_state_t st;
  dwell_state_t next_st;
  logic         run;
  logic         tick;

  // A zero dwell count disables switching altogether
  assign run = measureActive && (dwellCount != 6'h00);

  step_tick_gen u_tick (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .clear      (!st.active),
    .stepDouble (stepDouble),
    .tick       (tick)
  );

  always_comb begin
    next_st        = st;
    next_st.active = run;
    if (run && !st.active) begin
      next_st.ant   = 1'b0;
      next_st.steps = 6'h00;
      next_st.rssiA = 8'h00;
      next_st.rssiB = 8'h00;
    end else if (run && tick) begin
      // Dwelling continues whether or not hardware makes the choice
      if (st.steps + 6'd1 >= dwellCount) begin
        next_st.steps = 6'h00;
        next_st.ant   = !st.ant;
        if (st.ant) begin
          next_st.rssiB = rssi;
        end else begin
          next_st.rssiA = rssi;
        end
      end else begin
        next_st.steps = st.steps + 6'd1;
      end
    end
    if (!run && st.active && hwEnable) begin
      next_st.finalAnt = (st.rssiB > st.rssiA);
    end else if (!hwEnable && swLoad) begin
      next_st.finalAnt = swSelect;
    end
  end

  assign antennaSel = st.active ? st.ant : st.finalAnt;
  assign measuring  = st.active;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : antenna_dwell_ctrl
`default_nettype wire

// File: tx_ramp_and_antenna_dwell_timing.sv
// Purpose: APB registers, transmit strobe ramp sequencing and antenna dwell control
// Assumes: One clock mclk; txRequest and measureActive are synchronous levels
// Notes:   Strobes are active low; zero-wait APB slave
//
// Contract
// - Diversity enabled: hardware picks the antenna
// - Diversity disabled: software select and load bits
// - Dwell intervals still stepped without hardware choice
// - Bit 6 reserved: writes ignored, reads zero
// - Six-bit dwell in 20 or 40 clock steps
// - Zero dwell count disables antenna switching
// - Bits 7:4 gap first to second strobe
// - Strobes drive command and power-enable pins
// - Bits 3:0 gap second to third strobe
// - Ramp-down gap third to second strobe release
// - Ramp-down gap second to first strobe release
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tx_ramp_cfg.svh"
module tx_ramp_and_antenna_dwell_timing (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        txRequest,
  input  wire logic        measureActive,
  input  wire logic [7:0]  rssi,
  output logic             txStrobeA_n,
  output logic             txStrobeB_n,
  output logic             txStrobeC_n,
  output logic             txCommandPin_n,
  output logic             txPowerEnablePin_n,
  output logic             antennaSelect
);
  import tx_ramp_pkg::*;

  typedef enum logic [2:0] {
    DEC_NONE  = 3'd0,
    DEC_DWELL = 3'd1,
    DEC_UP    = 3'd2,
    DEC_DOWN  = 3'd3,
    DEC_CTRL  = 3'd4,
    DEC_STAT  = 3'd5
  } reg_sel_t;

  typedef struct packed {
    reg8_t       dwell;
    reg8_t       rampUp;
    reg8_t       rampDown;
    reg8_t       ctrl;
    logic        swLoad;
    logic [31:0] rdata;
    logic        err;
    ramp_state_t ramp;
    logic [3:0]  gapCnt;
    logic        strobeA;
    logic        strobeB;
    logic        strobeC;
    logic        reqSeen;
  } top_state_t;

  top_state_t  st;
  top_state_t  next_st;
  reg_sel_t    setupSel;
  reg_sel_t    accessSel;
  logic        wrAccess;
  logic        stepTick;
  logic        phaseClear;
  logic        gapDone;
  logic [3:0]  curGap;
  logic        antSel;
  logic        measuring;
  logic        stepDouble;

  function automatic reg_sel_t decode(input logic [11:0] addr);
    if (addr == {`IDX_DWELL, 2'b00}) begin
      decode = DEC_DWELL;
    end else if (addr == {`IDX_RAMP_UP, 2'b00}) begin
      decode = DEC_UP;
    end else if (addr == {`IDX_RAMP_DOWN, 2'b00}) begin
      decode = DEC_DOWN;
    end else if (addr == {`IDX_CTRL, 2'b00}) begin
      decode = DEC_CTRL;
    end else if (addr == {`IDX_STATUS, 2'b00}) begin
      decode = DEC_STAT;
    end else begin
      decode = DEC_NONE;
    end
  endfunction : decode

  assign setupSel   = decode(paddr);
  assign accessSel  = decode(paddr);
  assign wrAccess   = psel && penable && pwrite && pstrb[0];
  assign pready     = psel && penable;
  assign prdata     = st.rdata;
  assign pslverr    = psel && penable && st.err;
  assign stepDouble = st.ctrl[`CTRL_DOUBLE_BIT];

  // Gap of the phase now running
  always_comb begin
    case (st.ramp)
      RAMP_UP_B: curGap = st.rampUp[`GAP_HI_MSB:`GAP_HI_LSB];
      RAMP_UP_C: curGap = st.rampUp[`GAP_LO_MSB:0];
      RAMP_DN_B: curGap = st.rampDown[`GAP_HI_MSB:`GAP_HI_LSB];
      RAMP_DN_A: curGap = st.rampDown[`GAP_LO_MSB:0];
      default:   curGap = 4'h0;
    endcase
  end

  assign gapDone    = stepTick && (st.gapCnt + 4'd1 >= curGap);
  assign phaseClear = (st.ramp == RAMP_IDLE) || (st.ramp == RAMP_ON)
                      || (!txRequest && ((st.ramp == RAMP_UP_B) || (st.ramp == RAMP_UP_C)));

  step_tick_gen u_ramp_tick (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .clear      (phaseClear),
    .stepDouble (stepDouble),
    .tick       (stepTick)
  );

  antenna_dwell_ctrl u_dwell (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .hwEnable      (st.dwell[`DWELL_HWEN_BIT]),
    .dwellCount    (st.dwell[`DWELL_CNT_MSB:0]),
    .stepDouble    (stepDouble),
    .measureActive (measureActive),
    .rssi          (rssi),
    .swSelect      (st.ctrl[`CTRL_SWSEL_BIT]),
    .swLoad        (st.swLoad),
    .antennaSel    (antSel),
    .measuring     (measuring)
  );

  always_comb begin
    next_st         = st;
    next_st.swLoad  = 1'b0;
    next_st.reqSeen = txRequest;
    // Read data and error captured in the setup phase
    if (psel && !penable) begin
      next_st.err   = (setupSel == DEC_NONE);
      next_st.rdata = 32'h0000_0000;
      case (setupSel)
        DEC_DWELL: next_st.rdata[7:0] = st.dwell;
        DEC_UP:    next_st.rdata[7:0] = st.rampUp;
        DEC_DOWN:  next_st.rdata[7:0] = st.rampDown;
        DEC_CTRL:  next_st.rdata[7:0] = st.ctrl;
        DEC_STAT:  next_st.rdata[11:0] = {st.ramp, measuring, antSel,
                                          st.strobeC, st.strobeB, st.strobeA, 1'b0};
        default:   next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (wrAccess) begin
      if (accessSel == DEC_DWELL) begin
        next_st.dwell = pwdata[7:0] & 8'hBF;
      end else if (accessSel == DEC_UP) begin
        next_st.rampUp = pwdata[7:0];
      end else if (accessSel == DEC_DOWN) begin
        next_st.rampDown = pwdata[7:0];
      end else if (accessSel == DEC_CTRL) begin
        next_st.ctrl   = pwdata[7:0] & 8'h03;
        next_st.swLoad = pwdata[`CTRL_LOAD_BIT];
      end
    end
    if (stepTick) begin
      next_st.gapCnt = st.gapCnt + 4'd1;
    end
    case (st.ramp)
      RAMP_IDLE: begin
        next_st.gapCnt = 4'h0;
        if (txRequest && !st.reqSeen) begin
          next_st.strobeA = 1'b1;
          if (st.rampUp[`GAP_HI_MSB:`GAP_HI_LSB] != 4'h0) begin
            next_st.ramp = RAMP_UP_B;
          end else begin
            next_st.strobeB = 1'b1;
            if (st.rampUp[`GAP_LO_MSB:0] != 4'h0) begin
              next_st.ramp = RAMP_UP_C;
            end else begin
              next_st.strobeC = 1'b1;
              next_st.ramp    = RAMP_ON;
            end
          end
        end
      end
      RAMP_UP_B, RAMP_UP_C, RAMP_ON: begin
        if (!txRequest) begin
          next_st.gapCnt  = 4'h0;
          next_st.strobeC = 1'b0;
          if (st.rampDown[`GAP_HI_MSB:`GAP_HI_LSB] != 4'h0 && st.strobeB) begin
            next_st.ramp = RAMP_DN_B;
          end else begin
            next_st.strobeB = 1'b0;
            if (st.rampDown[`GAP_LO_MSB:0] != 4'h0) begin
              next_st.ramp = RAMP_DN_A;
            end else begin
              next_st.strobeA = 1'b0;
              next_st.ramp    = RAMP_IDLE;
            end
          end
        end else if (st.ramp == RAMP_UP_B && gapDone) begin
          next_st.gapCnt  = 4'h0;
          next_st.strobeB = 1'b1;
          if (st.rampUp[`GAP_LO_MSB:0] != 4'h0) begin
            next_st.ramp = RAMP_UP_C;
          end else begin
            next_st.strobeC = 1'b1;
            next_st.ramp    = RAMP_ON;
          end
        end else if (st.ramp == RAMP_UP_C && gapDone) begin
          next_st.gapCnt  = 4'h0;
          next_st.strobeC = 1'b1;
          next_st.ramp    = RAMP_ON;
        end
      end
      RAMP_DN_B: begin
        if (gapDone) begin
          next_st.gapCnt  = 4'h0;
          next_st.strobeB = 1'b0;
          if (st.rampDown[`GAP_LO_MSB:0] != 4'h0) begin
            next_st.ramp = RAMP_DN_A;
          end else begin
            next_st.strobeA = 1'b0;
            next_st.ramp    = RAMP_IDLE;
          end
        end
      end
      RAMP_DN_A: begin
        if (gapDone) begin
          next_st.gapCnt  = 4'h0;
          next_st.strobeA = 1'b0;
          next_st.ramp    = RAMP_IDLE;
        end
      end
      default: begin
        next_st.ramp = RAMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st          <= '0;
      st.dwell    <= `DWELL_RST;
      st.rampUp   <= `RAMP_UP_RST;
      st.rampDown <= `RAMP_DOWN_RST;
      st.ctrl     <= `CTRL_RST;
      st.ramp     <= RAMP_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign txStrobeA_n        = !st.strobeA;
  assign txStrobeB_n        = !st.strobeB;
  assign txStrobeC_n        = !st.strobeC;
  assign txCommandPin_n     = !st.strobeA;
  assign txPowerEnablePin_n = !st.strobeB;
  assign antennaSelect      = antSel;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_RSVD_ZERO: assert property (st.dwell[`DWELL_RSVD_BIT] == 1'b0)
    else $error("reserved dwell bit is set");
  AST_ORDER_B: assert property (st.strobeB |-> st.strobeA)
    else $error("second strobe active without first");
  AST_ORDER_C: assert property (st.strobeC |-> st.strobeB)
    else $error("third strobe active without second");
  AST_ZERO_GAPS: assert property ((st.ramp == RAMP_IDLE) && txRequest && !st.reqSeen
      && (st.rampUp == 8'h00) |=> st.strobeA && st.strobeB && st.strobeC)
    else $error("zero gaps did not assert all strobes together");
  AST_GAP1_HOLD: assert property ((st.ramp == RAMP_IDLE) ##1 (st.ramp == RAMP_UP_B)
      && !stepDouble && (st.rampUp[7:4] == 4'h1) && txRequest
      |-> !st.strobeB [*8] ##13 (st.strobeB || !txRequest))
    else $error("second strobe not asserted one step after first");
  AST_GAP2_WAIT: assert property ((st.ramp == RAMP_UP_C) |-> !st.strobeC)
    else $error("third strobe asserted before its gap ended");
  AST_DOWN_B: assert property ((st.ramp == RAMP_DN_B) |-> !st.strobeC && st.strobeB)
    else $error("ramp-down order wrong while releasing second strobe");
  AST_DOWN_A: assert property ((st.ramp == RAMP_DN_A) |-> !st.strobeB && st.strobeA)
    else $error("ramp-down order wrong while releasing first strobe");
  AST_PINS: assert property ((txCommandPin_n == txStrobeA_n)
      && (txPowerEnablePin_n == txStrobeB_n))
    else $error("pins do not follow their strobes");
  AST_NO_SWITCH: assert property ((st.dwell[5:0] == 6'h00) |=> !measuring)
    else $error("antenna switching with zero dwell");
  AST_SW_LOAD: assert property (!st.dwell[7] && !measuring && st.swLoad
      |=> antennaSelect == $past(st.ctrl[`CTRL_SWSEL_BIT]))
    else $error("software antenna load not applied");
endmodule : tx_ramp_and_antenna_dwell_timing
`default_nettype wire

// File: tx_radio_model.sv
// Purpose: Far-side radio model giving signal strength per antenna and watching pin order
// Assumes: Antenna 1 is the stronger path
// Notes:   orderFault stays high once power is enabled without the command pin
`timescale 1ns/1ps
`default_nettype none
module tx_radio_model #(
  parameter logic [7:0] RSSI_A = 8'h30,
  parameter logic [7:0] RSSI_B = 8'h70
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       txCommandPin_n,
  input  wire logic       txPowerEnablePin_n,
  input  wire logic       antennaSelect,
  output logic [7:0]      rssi,
  output logic            orderFault
);
  // Strength follows the antenna that the switch has selected
  assign rssi = antennaSelect ? RSSI_B : RSSI_A;

  // The power amplifier must never run without the command pin
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      orderFault <= 1'b0;
    end else if (!txPowerEnablePin_n && txCommandPin_n) begin
      orderFault <= 1'b1;
    end
  end
endmodule : tx_radio_model
`default_nettype wire

// File: test_tx_ramp_and_antenna_dwell_timing.sv
// Purpose: Self-checking bench for transmit ramp and antenna dwell timing
// Assumes: Zero-wait APB slave; strobes active low
// Notes:   Gaps are measured in clocks with one clock of slack
`timescale 1ns/1ps
`default_nettype none
`include "tx_ramp_cfg.svh"
module test_tx_ramp_and_antenna_dwell_timing;
  localparam logic [11:0] A_DWELL = {`IDX_DWELL, 2'b00};
  localparam logic [11:0] A_UP    = {`IDX_RAMP_UP, 2'b00};
  localparam logic [11:0] A_DN    = {`IDX_RAMP_DOWN, 2'b00};
  localparam logic [11:0] A_CTRL  = {`IDX_CTRL, 2'b00};
  localparam logic [11:0] A_STAT  = {`IDX_STATUS, 2'b00};
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        txRequest, measureActive, orderFault, antennaSelect;
  logic [7:0]  rssi;
  logic        txStrobeA_n, txStrobeB_n, txStrobeC_n, txCommandPin_n, txPowerEnablePin_n;
  int          numErrors, samplesChecked;

  tx_ramp_and_antenna_dwell_timing tx_ramp_and_antenna_dwell_timing_i (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .txRequest(txRequest), .measureActive(measureActive), .rssi(rssi),
    .txStrobeA_n(txStrobeA_n), .txStrobeB_n(txStrobeB_n), .txStrobeC_n(txStrobeC_n),
    .txCommandPin_n(txCommandPin_n), .txPowerEnablePin_n(txPowerEnablePin_n),
    .antennaSelect(antennaSelect));

  tx_radio_model tx_radio_model_i (
    .mclk(mclk), .rst_n(rst_n), .txCommandPin_n(txCommandPin_n),
    .txPowerEnablePin_n(txPowerEnablePin_n), .antennaSelect(antennaSelect),
    .rssi(rssi), .orderFault(orderFault));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic reportAndStop;
    $display("errors %0d checks %0d", numErrors, samplesChecked);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : reportAndStop

  task automatic fail(input string what);
    numErrors++;
    $display("unexpected at %0t: %s", $time, what);
    reportAndStop();
  endtask : fail

  task automatic check(input logic ok, input string what);
    samplesChecked++;
    if (ok !== 1'b1) begin
      numErrors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check

  function automatic bit near(input int n, input int e);
    return n >= e - 1 && n <= e + 1;
  endfunction : near

  function automatic logic pick(input int k);
    case (k)
      0:       return txStrobeA_n;
      1:       return txStrobeB_n;
      default: return txStrobeC_n;
    endcase
  endfunction : pick

  // Setup, then access held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int i;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) fail("no pready");
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {24'h000000, d}, q, e);
  endtask : wr

  task automatic waitLvl(input int k, input logic lvl, output int n);
    n = 0;
    while (pick(k) !== lvl) begin
      @(negedge mclk);
      n++;
      if (n > 2000) fail("strobe wait bound");
    end
  endtask : waitLvl

  task automatic regCase;
    logic [31:0] q;
    logic        e;
    apb(1'b0, A_UP, 32'h0, q, e);
    check(q === 32'h00000000 && e === 1'b0, "ramp-up reset value");
    apb(1'b0, A_STAT, 32'h0, q, e);
    check(q === 32'h00000040 && e === 1'b0, "status at idle");
    wr(A_DWELL, 8'hBF);
    apb(1'b0, A_DWELL, 32'h0, q, e);
    check((q[7:0] & 8'hBF) === 8'hBF, "dwell readback");
    wr(A_DWELL, 8'h00);
    wr(A_DN, 8'hA5);
    apb(1'b0, A_DN, 32'h0, q, e);
    check(q[7:0] === 8'hA5, "ramp-down readback");
    apb(1'b1, 12'h03C, 32'h000000FF, q, e);
    check(e === 1'b1, "unmapped write accepted");
    apb(1'b0, 12'h03C, 32'h0, q, e);
    check(e === 1'b1 && q === 32'h00000000, "unmapped read");
  endtask : regCase

  task automatic rampCase(input logic [3:0] g1, g2, g3, g4, input logic dbl);
    int n;
    int u;
    u = dbl ? `STEP_LONG : `STEP_SHORT;
    wr(A_CTRL, {7'h00, dbl});
    wr(A_UP, {g1, g2});
    wr(A_DN, {g3, g4});
    @(posedge mclk);
    txRequest <= 1'b1;
    waitLvl(0, 1'b0, n);
    check(n <= 3, "strobe A late");
    waitLvl(1, 1'b0, n);
    check(near(n, g1 * u), "gap A to B");
    check(g2 == 0 || txStrobeC_n === 1'b1, "strobe C early");
    waitLvl(2, 1'b0, n);
    check(near(n, g2 * u), "gap B to C");
    repeat (2) @(negedge mclk);
    check(txCommandPin_n === 1'b0 && txPowerEnablePin_n === 1'b0, "pins idle");
    @(posedge mclk);
    txRequest <= 1'b0;
    waitLvl(2, 1'b1, n);
    check(n <= 3, "strobe C release late");
    waitLvl(1, 1'b1, n);
    check(near(n, g3 * u), "gap C to B release");
    waitLvl(0, 1'b1, n);
    check(near(n, g4 * u), "gap B to A release");
    repeat (4) @(negedge mclk);
    check(txCommandPin_n === 1'b1 && txPowerEnablePin_n === 1'b1, "pins held");
  endtask : rampCase

  task automatic antCase(input logic hw, input logic [5:0] d, input logic dbl,
                         output int flips);
    int   n;
    int   t1;
    int   gap;
    logic prev;
    wr(A_CTRL, {7'h00, dbl});
    wr(A_DWELL, {hw, 1'b0, d});
    @(posedge mclk);
    measureActive <= 1'b1;
    flips = 0;
    t1    = 0;
    gap   = 0;
    prev  = antennaSelect;
    for (n = 0; n < 200; n++) begin
      @(negedge mclk);
      if (antennaSelect !== prev) begin
        flips++;
        if (flips == 2) gap = n - t1;
        t1 = n;
      end
      prev = antennaSelect;
    end
    check(d == 0 || near(gap, d * (dbl ? 40 : 20)), "dwell period");
    @(posedge mclk);
    measureActive <= 1'b0;
    repeat (4) @(negedge mclk);
  endtask : antCase

  initial begin
    int f;
    numErrors      = 0;
    samplesChecked = 0;
    rst_n          = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 12'h000;
    pwdata         = 32'h00000000;
    pstrb          = 4'hF;
    txRequest      = 1'b0;
    measureActive  = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    regCase();
    rampCase(4'h1, 4'h2, 4'h2, 4'h1, 1'b0);
    rampCase(4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
    rampCase(4'hF, 4'h1, 4'h1, 4'hF, 1'b1);
    antCase(1'b1, 6'h02, 1'b0, f);
    check(f >= 3, "no hardware switching");
    check(antennaSelect === 1'b1, "hardware pick");
    antCase(1'b0, 6'h01, 1'b1, f);
    check(f >= 3, "no stepping without hardware");
    wr(A_CTRL, 8'h04);
    repeat (2) @(negedge mclk);
    check(antennaSelect === 1'b0, "software select zero");
    wr(A_CTRL, 8'h06);
    repeat (2) @(negedge mclk);
    check(antennaSelect === 1'b1, "software select one");
    antCase(1'b1, 6'h00, 1'b0, f);
    check(f == 0, "switching at zero dwell");
    check(orderFault === 1'b0, "power without command");
    reportAndStop();
  end
endmodule : test_tx_ramp_and_antenna_dwell_timing
`default_nettype wire
